// [rtl/dds_control_word_one_low.sv]
// first dds control word, low half: shadow, update alignment, controls
`timescale 1ns/1ps
`default_nettype none

module dds_control_word_one_low
    import dds_cw1_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register port from the serial engine
    input wire logic wr_en,
    input wire logic [CW_WIDTH-1:0] wr_data,
    output logic [CW_WIDTH-1:0] rd_data,
    // update sources and timing
    input wire logic io_update,
    input wire logic [PROFILE_WIDTH-1:0] profile_select_pins,
    input wire logic sync_tick,
    input wire logic [CW_WIDTH-1:0] dds_control_word_two,
    // controls to the core
    output core_ctrl_t core_ctrl,
    output acc_ctrl_t acc_ctrl,
    output logic digital_sleep,
    output logic reference_clock_input_sleep
);

    // ------------------------------------------------------------
    // shadow register written by the host
    // ------------------------------------------------------------
    logic [CW_WIDTH-1:0] shadow;
    logic [PROFILE_WIDTH-1:0] last_profile;
    logic pending;
    logic ramp_pulse;
    logic phase_pulse;
    logic [CW_WIDTH-1:0] active;
    logic update_event;
    logic apply;
    // accumulator control flops
    logic ramp_clear;
    logic phase_clear;
    logic load_ramp;
    // core control flops
    logic wave_sine;
    logic keying_on;
    logic keying_auto;
    logic dac_off;
    logic fast_sleep;
    logic sdio_in;
    logic lsb_order;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            shadow <= CW1_RESET;
        end else if (wr_en) begin
            shadow <= wr_data & CW1_WRITE_MASK;
        end
    end

    assign rd_data = shadow;

    // ------------------------------------------------------------
    // update detection and sync alignment
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            last_profile <= '0;
        end else begin
            last_profile <= profile_select_pins;
        end
    end

    assign update_event = io_update
        || (profile_select_pins != last_profile);
    assign apply = pending && sync_tick;

    // a new event in the applying cycle stays pending
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pending <= 1'b0;
        end else begin
            pending <= update_event || (pending && !sync_tick);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            active <= CW1_RESET;
        end else if (apply) begin
            active <= shadow;
        end
    end

    // ------------------------------------------------------------
    // accumulator clears
    // ------------------------------------------------------------
    // autoclear pulses last from one sync edge to the next
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ramp_pulse <= 1'b0;
            phase_pulse <= 1'b0;
        end else if (sync_tick) begin
            ramp_pulse <= apply && shadow[RAMP_AUTOCLEAR_BIT];
            phase_pulse <= apply && shadow[PHASE_AUTOCLEAR_BIT];
        end
    end

    // static clear follows the applied word, autoclear the pulse
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ramp_clear <= 1'b0;
        end else begin
            ramp_clear <= active[RAMP_CLEAR_BIT] || ramp_pulse;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_clear <= 1'b0;
        end else begin
            phase_clear <= active[PHASE_CLEAR_BIT] || phase_pulse;
        end
    end

    // reload only has meaning while the ramp generator runs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            load_ramp <= 1'b0;
        end else begin
            load_ramp <= apply
                && shadow[LOAD_RAMP_RATE_BIT]
                && dds_control_word_two[RAMP_ENABLE_BIT];
        end
    end

    assign acc_ctrl = '{
        ramp_acc_clear: ramp_clear,
        phase_acc_clear: phase_clear,
        load_ramp_rate: load_ramp
    };

    // ------------------------------------------------------------
    // waveform select
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wave_sine <= CW1_RESET[SINE_SELECT_BIT];
        end else begin
            wave_sine <= active[SINE_SELECT_BIT];
        end
    end

    // ------------------------------------------------------------
    // amplitude keying
    // ------------------------------------------------------------
    // auto mode is masked here so the core never sees it ungated
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            keying_on <= CW1_RESET[KEYING_ENABLE_BIT];
            keying_auto <= 1'b0;
        end else begin
            keying_on <= active[KEYING_ENABLE_BIT];
            keying_auto <= active[AUTO_KEYING_BIT]
                && active[KEYING_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // update-gated power controls
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dac_off <= CW1_RESET[DAC_SLEEP_BIT];
            fast_sleep <= CW1_RESET[EXT_SLEEP_MODE_BIT];
        end else begin
            dac_off <= active[DAC_SLEEP_BIT];
            fast_sleep <= active[EXT_SLEEP_MODE_BIT];
        end
    end

    // ------------------------------------------------------------
    // serial port format
    // ------------------------------------------------------------
    // format changes only at an update, never inside a transfer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sdio_in <= CW1_RESET[SDIO_INPUT_ONLY_BIT];
            lsb_order <= CW1_RESET[LSB_FIRST_BIT];
        end else begin
            sdio_in <= active[SDIO_INPUT_ONLY_BIT];
            lsb_order <= active[LSB_FIRST_BIT];
        end
    end

    assign core_ctrl = '{
        sine_select: wave_sine,
        keying_enable: keying_on,
        auto_keying: keying_auto,
        dac_sleep: dac_off,
        fast_recovery_sleep: fast_sleep,
        sdio_input_only: sdio_in,
        lsb_first: lsb_order
    };

    // ------------------------------------------------------------
    // immediate power controls
    // ------------------------------------------------------------

    // these two act without waiting for an update
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            digital_sleep <= CW1_RESET[DIGITAL_SLEEP_BIT];
            reference_clock_input_sleep <= CW1_RESET[REFERENCE_CLOCK_INPUT_SLEEP_BIT];
        end else begin
            digital_sleep <= shadow[DIGITAL_SLEEP_BIT];
            reference_clock_input_sleep <= shadow[REFERENCE_CLOCK_INPUT_SLEEP_BIT];
        end
    end

endmodule

`default_nettype wire

// [shared/dds_cw1_pkg.sv]
// constants and carrier types for the first dds control word, low half
package dds_cw1_pkg;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned SINE_SELECT_BIT = 16;
    localparam int unsigned LOAD_RAMP_RATE_BIT = 15;
    localparam int unsigned RAMP_AUTOCLEAR_BIT = 14;
    localparam int unsigned PHASE_AUTOCLEAR_BIT = 13;
    localparam int unsigned RAMP_CLEAR_BIT = 12;
    localparam int unsigned PHASE_CLEAR_BIT = 11;
    localparam int unsigned AUTO_KEYING_BIT = 9;
    localparam int unsigned KEYING_ENABLE_BIT = 8;
    localparam int unsigned DIGITAL_SLEEP_BIT = 7;
    localparam int unsigned DAC_SLEEP_BIT = 6;
    localparam int unsigned REFERENCE_CLOCK_INPUT_SLEEP_BIT = 5;
    localparam int unsigned EXT_SLEEP_MODE_BIT = 3;
    localparam int unsigned SDIO_INPUT_ONLY_BIT = 1;
    localparam int unsigned LSB_FIRST_BIT = 0;
    localparam int unsigned RAMP_ENABLE_BIT = 19;

    // ------------------------------------------------------------
    // register layout
    // ------------------------------------------------------------
    localparam int unsigned CW_WIDTH = 32;
    localparam int unsigned PROFILE_WIDTH = 3;
    localparam logic [CW_WIDTH-1:0] CW1_RESET = 32'h0001_0008;
    // open positions 10, 4, 2 and everything above 16 stay zero
    localparam logic [CW_WIDTH-1:0] CW1_WRITE_MASK = 32'h0001_FBEB;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic sine_select;
        logic keying_enable;
        logic auto_keying;
        logic dac_sleep;
        logic fast_recovery_sleep;
        logic sdio_input_only;
        logic lsb_first;
    } core_ctrl_t;

    typedef struct packed {
        logic ramp_acc_clear;
        logic phase_acc_clear;
        logic load_ramp_rate;
    } acc_ctrl_t;

endpackage

// [test/dds_cw1_host.sv]
// host model driving the control word port
`timescale 1ns/1ps
`default_nettype none
module dds_cw1_host
    import dds_cw1_pkg::*;
(
    // clock
    input wire logic mclk,
    // register and update drive
    output logic wr_en,
    output logic [CW_WIDTH-1:0] wr_data,
    output logic io_update,
    output logic [PROFILE_WIDTH-1:0] profile_select_pins
);
    initial begin
        wr_en = 1'h0;
        wr_data = '0;
        io_update = 1'h0;
        profile_select_pins = '0;
    end
    // whole words only, so bit order never splits a value
    task automatic pulse_write(input logic [CW_WIDTH-1:0] d);
        @(posedge mclk);
        #1 wr_en = 1'h1;
        wr_data = d;
        @(posedge mclk);
        #1 wr_en = 1'h0;
    endtask
    task automatic send_update(input logic by_pins);
        @(posedge mclk);
        #1 if (by_pins) profile_select_pins += 3'h1;
        else io_update = 1'h1;
        @(posedge mclk);
        #1 io_update = 1'h0;
    endtask
endmodule
`default_nettype wire

// [test/dds_cw1_assertions.sv]
// port assertions for the control word block
`timescale 1ns/1ps
`default_nettype none
module dds_cw1_assertions
    import dds_cw1_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // watched signals
    input wire logic wr_en,
    input wire logic [CW_WIDTH-1:0] wr_data,
    input wire logic sync_tick,
    input wire logic [CW_WIDTH-1:0] dds_control_word_two,
    input wire logic [CW_WIDTH-1:0] rd_data,
    input wire core_ctrl_t core_ctrl,
    input wire acc_ctrl_t acc_ctrl,
    input wire logic digital_sleep,
    input wire logic reference_clock_input_sleep
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence tick_lately;
        $past(sync_tick) || $past(sync_tick, 2) || $past(sync_tick, 3);
    endsequence
    a_readback_masked: assert property (
        wr_en |=> rd_data == ($past(wr_data) & CW1_WRITE_MASK))
        else $error("readback mismatch");
    a_open_bits_zero: assert property (
        (rd_data & ~CW1_WRITE_MASK) == '0) else $error("open bits set");
    a_core_sleep_direct: assert property (
        wr_en |=> ##1 digital_sleep == $past(wr_data[DIGITAL_SLEEP_BIT], 2))
        else $error("digital sleep late");
    a_reference_clock_input_sleep_direct: assert property (
        wr_en |=> ##1 reference_clock_input_sleep == $past(wr_data[REFERENCE_CLOCK_INPUT_SLEEP_BIT], 2))
        else $error("reference_clock_input sleep late");
    a_ramp_load_cause: assert property (
        acc_ctrl.load_ramp_rate |-> $past(sync_tick) &&
        $past(rd_data[LOAD_RAMP_RATE_BIT]) &&
        $past(dds_control_word_two[RAMP_ENABLE_BIT]))
        else $error("ramp load without cause");
    a_core_after_tick: assert property (
        $changed(core_ctrl) |-> tick_lately) else $error("core moved");
    a_clear_after_tick: assert property (
        $changed(acc_ctrl) |-> tick_lately) else $error("clear moved");
    a_keying_gated: assert property (
        core_ctrl.auto_keying |-> core_ctrl.keying_enable)
        else $error("auto keying ungated");
endmodule
bind dds_control_word_one_low dds_cw1_assertions checker_inst (.*);
`default_nettype wire

// [test/dds_control_word_one_low_bench.sv]
// self-checking bench for the control word block
`timescale 1ns/1ps
`default_nettype none
module dds_control_word_one_low_bench import dds_cw1_pkg::*;;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic sync_tick = 1'h0;
    logic [CW_WIDTH-1:0] word_two = '0;
    logic wr_en, io_update, dsleep, rsleep;
    logic [CW_WIDTH-1:0] wr_data, rd_data;
    logic [PROFILE_WIDTH-1:0] pins;
    core_ctrl_t core;
    acc_ctrl_t acc;
    int errors = 0, checked = 0, cycles = 0, ramp_hi, phase_hi, loads;
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        sync_tick <= #1 (cycles % 8 == 7);
        ramp_hi <= ramp_hi + acc.ramp_acc_clear;
        phase_hi <= phase_hi + acc.phase_acc_clear;
        loads <= loads + acc.load_ramp_rate;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    dds_cw1_host host (.mclk(mclk), .wr_en(wr_en), .wr_data(wr_data),
        .io_update(io_update), .profile_select_pins(pins));
    dds_control_word_one_low dut (.mclk(mclk), .nrst(nrst), .wr_en(wr_en),
        .wr_data(wr_data), .rd_data(rd_data), .io_update(io_update),
        .profile_select_pins(pins), .sync_tick(sync_tick),
        .dds_control_word_two(word_two), .core_ctrl(core),
        .acc_ctrl(acc), .digital_sleep(dsleep), .reference_clock_input_sleep(rsleep));
    task automatic check(input logic [CW_WIDTH-1:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic upd(input logic by_pins);
        host.send_update(by_pins);
        repeat (16) @(posedge mclk);
        #1;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        #1 nrst = 1'h1;
        check(rd_data, CW1_RESET);
        check(core, 7'h44);
        check({acc, dsleep, rsleep}, '0);
        for (int i = 0; i < 2; i++) begin
            word_two = i << RAMP_ENABLE_BIT;
            host.pulse_write(32'h0000_E000);
            ramp_hi = 0;
            phase_hi = 0;
            loads = 0;
            upd(i[0]);
            check(loads, i);
            check(ramp_hi, 8);
            check(phase_hi, 8);
            check({core, acc}, '0);
        end
        host.pulse_write(32'h0000_0200);
        upd(1'h0);
        check(core, 7'h00);
        host.pulse_write('1);
        check(rd_data, CW1_WRITE_MASK);
        @(posedge mclk);
        #1 check({dsleep, rsleep}, 2'h3);
        check(core, 7'h00);
        upd(1'h1);
        check(core, 7'h7F);
        check(acc[2:1], 2'h3);
        host.pulse_write(32'h0000_0000);
        upd(1'h0);
        check({acc[2:1], core}, '0);
        check({dsleep, rsleep}, 2'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
